//--- hw/pmd_pkg.sv
// Constants and types shared by the prefixed move decoder.
package pmd_pkg;

  // ****************************************************************
  // Opcodes. Group opcodes carry a register index in bits 2..0.
  // ****************************************************************
  localparam logic [7:0] OP_PREFIX = 8'h11;
  localparam logic [7:0] OP_MOV_ABS_IMM = 8'hcf;
  localparam logic [7:0] OP_MOV_A_HL = 8'h8b;
  localparam logic [7:0] OP_MOV_R_IMM = 8'h50;
  localparam logic [7:0] OP_MOV_A_R = 8'h60;
  localparam logic [7:0] OP_MOV_R_A = 8'h70;
  localparam logic [7:0] OP_GROUP_MASK = 8'hf8;
  localparam logic [7:0] OP_MOV_PSW_IMM = 8'hc1;
  localparam logic [7:0] OP_MOV_PSW_A = 8'hc2;
  localparam logic [7:0] OP_MOV_A_PSW = 8'hc3;
  localparam logic [7:0] OP_MOV_ES_IMM = 8'hc4;
  localparam logic [7:0] OP_MOV_ES_A = 8'hc5;
  localparam logic [7:0] OP_MOV_A_ES = 8'hc6;
  localparam logic [7:0] OP_MOV_A_ABS = 8'hc7;
  localparam logic [7:0] OP_MOV_ABS_A = 8'hc8;
  localparam logic [7:0] OP_MOVW_AX_ABS = 8'hc9;
  localparam logic [7:0] OP_BR_D8 = 8'hca;
  localparam logic [7:0] OP_BR_D16 = 8'hcb;
  localparam logic [7:0] OP_TABLE_JMP = 8'hcc;
  localparam logic [7:0] OP_RESTORE_PSW = 8'hcd;

  // ****************************************************************
  // Registers, flags and address space.
  // ****************************************************************
  localparam logic [2:0] REG_X = 3'h0;
  localparam logic [2:0] REG_A = 3'h1;
  localparam logic [1:0] PAIR_HL = 2'h3;
  localparam int PSW_CY = 0;
  localparam int PSW_AC = 4;
  localparam int PSW_Z = 6;
  localparam int PSW_IE = 7;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [7:0] ES_RST = 8'h00;
  localparam logic [19:0] PC_RST = 20'h00000;
  localparam logic [63:0] REGS_RST = 64'h0;
  localparam logic [3:0] WIN_TOP = 4'hf;
  localparam logic [19:0] FLASH_LIMIT = 20'h10000;
  localparam logic [11:0] TABLE_PAGE = 12'h000;
  localparam logic [7:0] TABLE_MIN = 8'h80;
  localparam logic [7:0] TABLE_MAX = 8'hbf;

  // ****************************************************************
  // Execute clocks and register map.
  // ****************************************************************
  localparam logic [2:0] CYC_RAM = 3'h1;
  localparam logic [2:0] CYC_FLASH = 3'h4;
  localparam logic [2:0] CYC_PSW = 3'h3;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_REGS_LO = 8'h08;
  localparam logic [7:0] OFF_REGS_HI = 8'h0c;
  localparam logic [7:0] OFF_PC = 8'h10;
  localparam int CTRL_RUN = 0;
  localparam int ST_ILL = 1;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef logic [7:0][7:0] pmd_regs_t;
  typedef enum logic [1:0] {PH_OPCODE, PH_OPERAND, PH_EXEC} pmd_phase_e;
  typedef struct packed {
    pmd_regs_t r;
  } pmd_bank_s;

endpackage

//--- hw/pmd_regbank.sv
// Eight-entry byte register bank of the core.
`timescale 1ns/1ps
`default_nettype none
module pmd_regbank
  import pmd_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Byte write port.
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [7:0] wrData,
  // All eight registers, straight from the flip-flops.
  output var pmd_regs_t regsOut
);

  pmd_bank_s bank_q;
  pmd_bank_s bank_d;

  // One byte write per clock is all the move group ever needs.
  always_comb begin
    bank_d = bank_q;
    if (wrEn) begin
      bank_d.r[wrIdx] = wrData;
    end
  end

  // Register the bank.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bank_q <= '{r: REGS_RST};
    end else begin
      bank_q <= bank_d;
    end
  end

  assign regsOut = bank_q.r;

  a_bank_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    wrEn |=> regsOut[$past(wrIdx)] == $past(wrData))
    else $error("Register bank write was lost.");

endmodule // pmd_regbank
`default_nettype wire

//--- hw/pmd_decoder.sv
// Prefixed 8-bit data-transfer decoder and executor with APB access.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pmd_decoder
  import pmd_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction fetch path.
  output logic fetchReq,
  output logic [19:0] fetchAddr,
  input wire logic fetchValid,
  input wire logic [7:0] fetchData,
  // Data memory bus.
  output logic memRd,
  output logic memWr,
  output logic [19:0] memAddr,
  output logic [7:0] memWdata,
  input wire logic [7:0] memRdata,
  // Interrupt and DMA arbitration.
  input wire logic irqReq,
  output logic irqAck,
  input wire logic dmaReq,
  output logic dmaGrant
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    pmd_phase_e phase;
    logic [19:0] pc;
    logic [7:0] op;
    logic [23:0] opnd;
    logic [1:0] need;
    logic pfx;
    logic curPfx;
    logic [7:0] es;
    logic [7:0] program_status_word;
    logic [7:0] savedPsw;
    logic [19:0] addr;
    logic [7:0] wdata;
    logic [7:0] tmp;
    logic rd;
    logic wr;
    logic hi;
    logic first;
    logic [2:0] waitCnt;
    logic run;
    logic illegal;
    logic [31:0] prdata;
    logic pslverr;
  } pmd_state_s;

  localparam pmd_state_s ST_RST = '{phase: PH_OPCODE, pc: PC_RST, es: ES_RST,
                                    program_status_word: PSW_RST, savedPsw: PSW_RST, default: '0};

  pmd_state_s st_q;
  pmd_state_s st_d;
  pmd_regs_t regs;
  logic wrEn;
  logic [2:0] wrIdx;
  logic [7:0] wrData;
  logic boundary;
  logic launch;
  logic done;
  logic lPfx;
  logic wHit;
  logic execLast;
  logic [7:0] lOp;
  logic [23:0] lOpnd;
  logic [3:0] window;
  logic [15:0] abs16;
  logic [7:0] grp;
  logic [2:0] rIdx;
  logic [31:0] rdVal;
  logic [7:0] pswSrc;

  // Operand bytes that follow each opcode.
  function automatic logic [1:0] opLen(input logic [7:0] op);
    logic [1:0] len;
    len = 2'h0;
    if ((op & OP_GROUP_MASK) == OP_MOV_R_IMM) begin
      len = 2'h1;
    end
    case (op)
      OP_MOV_PSW_IMM, OP_MOV_ES_IMM, OP_BR_D8, OP_TABLE_JMP: len = 2'h1;
      OP_MOV_A_ABS, OP_MOV_ABS_A, OP_MOVW_AX_ABS, OP_BR_D16: len = 2'h2;
      OP_MOV_ABS_IMM: len = 2'h3;
      default: len = len;
    endcase
    return len;
  endfunction

  // Code flash sits below the limit; everything above is RAM or SFR.
  function automatic logic isFlash(input logic [19:0] a);
    return a < FLASH_LIMIT;
  endfunction

  // Register pair p is built from bytes 2p+1 (high) and 2p (low).
  function automatic logic [15:0] pairOf(input pmd_regs_t rg, input logic [1:0] p);
    return {rg[{p, 1'h1}], rg[{p, 1'h0}]};
  endfunction

  pmd_regbank u_bank (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .wrEn(wrEn),
    .wrIdx(wrIdx),
    .wrData(wrData),
    .regsOut(regs)
  );

  // ****************************************************************
  // Bus outputs.
  // ****************************************************************
  // Arbitration only happens at a clean instruction boundary.
  assign boundary = (st_q.phase == PH_OPCODE) && !st_q.pfx;
  assign dmaGrant = boundary && dmaReq;
  assign irqAck = boundary && !dmaReq && st_q.run && irqReq && st_q.program_status_word[PSW_IE];
  assign fetchReq = (st_q.phase != PH_EXEC) && (st_q.run || !boundary) && !dmaGrant && !irqAck;
  assign fetchAddr = st_q.pc;
  assign execLast = (st_q.phase == PH_EXEC) && (st_q.waitCnt == 3'h0);
  assign memRd = (st_q.phase == PH_EXEC) && st_q.rd;
  assign memWr = execLast && st_q.wr;
  assign memAddr = st_q.addr;
  assign memWdata = st_q.wdata;
  assign prdata = st_q.prdata;
  assign pslverr = st_q.pslverr;
  assign pready = 1'h1;
  assign pswSrc = (st_q.op == OP_MOV_PSW_IMM) ? st_q.opnd[7:0] : regs[REG_A];

  // APB read decode; an unmapped offset answers with an error.
  always_comb begin
    wHit = 1'h1;
    rdVal = 32'h0;
    case (paddr)
      OFF_CTRL: rdVal = {31'h0, st_q.run};
      OFF_STATUS: rdVal = {8'h00, st_q.es, st_q.program_status_word, 5'h00, !boundary, st_q.illegal, st_q.pfx};
      OFF_REGS_LO: rdVal = regs[3:0];
      OFF_REGS_HI: rdVal = regs[7:4];
      OFF_PC: rdVal = {12'h000, st_q.pc};
      default: wHit = 1'h0;
    endcase
  end

  // ****************************************************************
  // Next state.
  // ****************************************************************
  // The APB part comes first so that a later hardware set of the
  // illegal flag wins over a software clear in the same cycle.
  always_comb begin
    st_d = st_q;
    wrEn = 1'h0;
    wrIdx = REG_A;
    wrData = 8'h00;
    launch = 1'h0;
    done = 1'h0;
    lOp = st_q.op;
    lOpnd = st_q.opnd;
    lPfx = st_q.curPfx;
    window = WIN_TOP;
    abs16 = 16'h0000;
    grp = st_q.op & OP_GROUP_MASK;
    rIdx = st_q.op[2:0];
    if (psel && !penable) begin
      st_d.prdata = pwrite ? 32'h0 : rdVal;
      st_d.pslverr = !wHit;
    end
    if (psel && penable && pwrite && wHit) begin
      if (paddr == OFF_CTRL) begin
        st_d.run = pwdata[CTRL_RUN];
      end
      if (paddr == OFF_STATUS && pwdata[ST_ILL]) begin
        st_d.illegal = 1'h0;
      end
    end
    case (st_q.phase)
      PH_OPCODE: begin
        if (irqAck) begin
          st_d.savedPsw = st_q.program_status_word;
          st_d.program_status_word[PSW_IE] = 1'h0;
        end else if (fetchReq && fetchValid) begin
          st_d.pc = st_q.pc + 20'h00001;
          if (fetchData == OP_PREFIX && !st_q.pfx) begin
            st_d.pfx = 1'h1;
          end else begin
            st_d.op = fetchData;
            st_d.need = opLen(fetchData);
            st_d.curPfx = st_q.pfx;
            lOp = fetchData;
            lPfx = st_q.pfx;
            if (opLen(fetchData) == 2'h0) begin
              launch = 1'h1;
            end else begin
              st_d.phase = PH_OPERAND;
            end
          end
        end
      end
      PH_OPERAND: begin
        if (fetchValid) begin
          st_d.pc = st_q.pc + 20'h00001;
          st_d.opnd = {st_q.opnd[15:0], fetchData};
          st_d.need = st_q.need - 2'h1;
          lOpnd = st_d.opnd;
          launch = (st_q.need == 2'h1);
        end
      end
      PH_EXEC: begin
        st_d.first = 1'h0;
        if (st_q.waitCnt != 3'h0) begin
          st_d.waitCnt = st_q.waitCnt - 3'h1;
        end else begin
          done = 1'h1;
          if (grp == OP_MOV_R_IMM) begin
            wrEn = 1'h1;
            wrIdx = rIdx;
            wrData = st_q.opnd[7:0];
          end else if (grp == OP_MOV_A_R || grp == OP_MOV_R_A) begin
            if (rIdx == REG_A) begin
              st_d.illegal = 1'h1;
            end else begin
              wrEn = 1'h1;
              wrIdx = (grp == OP_MOV_A_R) ? REG_A : rIdx;
              wrData = (grp == OP_MOV_A_R) ? regs[rIdx] : regs[REG_A];
            end
          end else begin
            case (st_q.op)
              OP_MOV_PSW_IMM, OP_MOV_PSW_A: st_d.program_status_word = pswSrc;
              OP_MOV_ES_IMM: st_d.es = st_q.opnd[7:0];
              OP_MOV_ES_A: st_d.es = regs[REG_A];
              OP_RESTORE_PSW: st_d.program_status_word = st_q.savedPsw;
              OP_MOV_A_PSW, OP_MOV_A_ES, OP_MOV_A_HL, OP_MOV_A_ABS: begin
                wrEn = 1'h1;
                wrData = (st_q.op == OP_MOV_A_PSW) ? st_q.program_status_word :
                         (st_q.op == OP_MOV_A_ES) ? st_q.es : memRdata;
              end
              OP_MOV_ABS_A, OP_MOV_ABS_IMM: done = 1'h1;
              OP_BR_D8: st_d.pc = st_q.pc + {{12{st_q.opnd[7]}}, st_q.opnd[7:0]};
              OP_BR_D16: st_d.pc = st_q.pc + {{4{st_q.opnd[7]}}, st_q.opnd[7:0],
                                              st_q.opnd[15:8]};
              OP_MOVW_AX_ABS, OP_TABLE_JMP: begin
                if (!st_q.rd) begin
                  done = 1'h1;
                end else if (!st_q.hi) begin
                  // Low byte first, then the odd address of the pair.
                  st_d.tmp = memRdata;
                  st_d.hi = 1'h1;
                  st_d.first = 1'h1;
                  st_d.addr[0] = 1'h1;
                  st_d.waitCnt = isFlash(st_q.addr) ? CYC_FLASH - 3'h1 : CYC_RAM - 3'h1;
                  done = 1'h0;
                  wrEn = (st_q.op == OP_MOVW_AX_ABS);
                  wrIdx = REG_X;
                  wrData = memRdata;
                end else if (st_q.op == OP_MOVW_AX_ABS) begin
                  wrEn = 1'h1;
                  wrData = memRdata;
                end else begin
                  st_d.pc = {TABLE_PAGE[11:8], memRdata, st_q.tmp};
                end
              end
              default: st_d.illegal = 1'h1;
            endcase
          end
          if (done) begin
            // The prefix dies with the instruction it widened.
            st_d.phase = PH_OPCODE;
            st_d.pfx = 1'h0;
            st_d.curPfx = 1'h0;
            st_d.rd = 1'h0;
            st_d.wr = 1'h0;
            st_d.hi = 1'h0;
          end
        end
      end
      default: st_d.phase = PH_OPCODE;
    endcase
    // Launch: form the address and the execute length.
    if (launch) begin
      window = lPfx ? st_q.es[3:0] : WIN_TOP;
      abs16 = {lOpnd[7:0], lOpnd[15:8]};
      st_d.phase = PH_EXEC;
      st_d.first = 1'h1;
      st_d.op = lOp;
      st_d.opnd = lOpnd;
      st_d.rd = 1'h0;
      st_d.wr = 1'h0;
      st_d.hi = 1'h0;
      st_d.waitCnt = CYC_RAM - 3'h1;
      case (lOp)
        OP_MOV_A_HL: begin
          st_d.addr = {window, pairOf(regs, PAIR_HL)};
          st_d.rd = 1'h1;
        end
        OP_MOV_A_ABS: begin
          st_d.addr = {window, abs16};
          st_d.rd = 1'h1;
        end
        OP_MOV_ABS_A: begin
          st_d.addr = {window, abs16};
          st_d.wr = 1'h1;
          st_d.wdata = regs[REG_A];
        end
        OP_MOV_ABS_IMM: begin
          st_d.addr = {window, lOpnd[15:8], lOpnd[23:16]};
          st_d.wr = 1'h1;
          st_d.wdata = lOpnd[7:0];
        end
        OP_MOVW_AX_ABS: begin
          st_d.addr = {window, abs16[15:1], 1'h0};
          st_d.rd = 1'h1;
        end
        OP_TABLE_JMP: begin
          // An odd or out-of-range table slot makes no access at all.
          if (lOpnd[7:0] >= TABLE_MIN && lOpnd[7:0] <= TABLE_MAX && !lOpnd[0]) begin
            st_d.addr = {TABLE_PAGE, lOpnd[7:0]};
            st_d.rd = 1'h1;
          end else begin
            st_d.illegal = 1'h1;
          end
        end
        OP_MOV_PSW_IMM, OP_MOV_PSW_A: st_d.waitCnt = CYC_PSW - 3'h1;
        default: st_d.rd = 1'h0;
      endcase
      if (st_d.rd && isFlash(st_d.addr)) begin
        st_d.waitCnt = CYC_FLASH - 3'h1;
      end
    end
  end

  // Register the whole state.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  sequence s_ram_read;
    memRd && !isFlash(memAddr) && st_q.first;
  endsequence

  sequence s_flash_read;
    memRd && isFlash(memAddr) && st_q.first;
  endsequence

  sequence s_psw_write;
    st_q.first && (st_q.phase == PH_EXEC) &&
      (st_q.op == OP_MOV_PSW_IMM || st_q.op == OP_MOV_PSW_A);
  endsequence

  a_ram_one_clk: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_ram_read |-> execLast)
    else $error("RAM read took more than one clock.");

  a_flash_four_clk: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_flash_read |-> !execLast[*3] ##1 execLast)
    else $error("Flash read did not take four clocks.");

  a_psw_three_clk: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_psw_write |-> !execLast ##1 !execLast ##1 execLast ##1 (st_q.program_status_word == $past(pswSrc)))
    else $error("Status word write wrong length or value.");

  a_flags_kept: assert property (@(posedge clk_sys) disable iff (!nrst)
    execLast && st_q.op != OP_MOV_PSW_IMM && st_q.op != OP_MOV_PSW_A &&
      st_q.op != OP_RESTORE_PSW |=> $stable({st_q.program_status_word[PSW_Z], st_q.program_status_word[PSW_AC], st_q.program_status_word[PSW_CY]}))
    else $error("A plain move changed a flag.");

  a_restore_flags: assert property (@(posedge clk_sys) disable iff (!nrst)
    execLast && st_q.op == OP_RESTORE_PSW |=> st_q.program_status_word == $past(st_q.savedPsw))
    else $error("Flags not restored from saved copy.");

  a_prefix_window: assert property (@(posedge clk_sys) disable iff (!nrst)
    (memRd || memWr) && st_q.op != OP_TABLE_JMP |->
      memAddr[19:16] == (st_q.curPfx ? st_q.es[3:0] : WIN_TOP))
    else $error("Data address window is wrong.");

  a_prefix_taken: assert property (@(posedge clk_sys) disable iff (!nrst)
    boundary && fetchReq && fetchValid && fetchData == OP_PREFIX |=> st_q.pfx && !irqAck && !dmaGrant)
    else $error("Prefix byte not recorded or arbitration opened.");

  a_prefix_one_shot: assert property (@(posedge clk_sys) disable iff (!nrst)
    execLast && !(st_q.rd && !st_q.hi &&
      (st_q.op == OP_MOVW_AX_ABS || st_q.op == OP_TABLE_JMP)) |=> !st_q.pfx && !st_q.curPfx)
    else $error("Prefix outlived its instruction.");

  a_word_even: assert property (@(posedge clk_sys) disable iff (!nrst)
    memRd && !st_q.hi && (st_q.op == OP_MOVW_AX_ABS || st_q.op == OP_TABLE_JMP) |-> !memAddr[0])
    else $error("Word access started on an odd address.");

  a_table_range: assert property (@(posedge clk_sys) disable iff (!nrst)
    memRd && st_q.op == OP_TABLE_JMP |-> memAddr[19:8] == TABLE_PAGE &&
      memAddr[7:0] >= TABLE_MIN && memAddr[7:0] <= TABLE_MAX)
    else $error("Table address outside its range.");

  a_self_move: assert property (@(posedge clk_sys) disable iff (!nrst)
    execLast && st_q.op == (OP_MOV_A_R | {5'h00, REG_A}) |-> !wrEn ##1 st_q.illegal)
    else $error("Accumulator self move not rejected.");

endmodule // pmd_decoder
`default_nettype wire

//--- verif/pmd_mem_model.sv
// Behavioural code memory, data memory and bus monitor facing the decoder.
`timescale 1ns/1ps
`default_nettype none
module pmd_mem_model (
  // Clock, reset and pacing.
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic slow,
  // Instruction fetch path.
  input wire logic fetchReq,
  input wire logic [19:0] fetchAddr,
  output logic fetchValid,
  output logic [7:0] fetchData,
  // Data memory bus.
  input wire logic memRd,
  input wire logic memWr,
  input wire logic [19:0] memAddr,
  input wire logic [7:0] memWdata,
  output logic [7:0] memRdata,
  // Arbitration seen from the core.
  input wire logic irqAck,
  input wire logic dmaGrant
);
  // ****************************************************************
  // Storage and logs.
  // ****************************************************************
  logic [7:0] code [256];
  logic [7:0] lastByte = 8'h00;
  logic tick = 1'b0;
  logic pfxOpen = 1'b0;
  logic [19:0] wAddr [$];
  logic [7:0] wData [$];
  logic [19:0] rAddr [$];
  int rLen [$];
  int runLen = 0;
  int viol = 0;
  int irqCnt = 0;

  // A slow path answers every other cycle; an idle bus shows junk, not the last byte.
  assign fetchValid = !slow || tick;
  assign fetchData = (fetchReq && fetchValid) ? code[fetchAddr[7:0]] : ~lastByte;
  // Read data follows the address, so every read can be predicted.
  assign memRdata = memRd ? (memAddr[7:0] ^ memAddr[19:12]) : ~lastByte;

  // Log fetches, accesses and grants at each edge.
  always @(posedge clk_sys) begin
    tick <= ~tick;
    if (nrst) begin
      if ((irqAck || dmaGrant) && pfxOpen) viol++;
      if (fetchReq && fetchValid) begin
        lastByte <= fetchData;
        pfxOpen <= (fetchData == 8'h11);
      end
      if (irqAck) irqCnt++;
      if (memWr) begin
        wAddr.push_back(memAddr);
        wData.push_back(memWdata);
      end
      if (memRd && runLen == 0) rAddr.push_back(memAddr);
      if (memRd) runLen++;
      else if (runLen > 0) begin
        rLen.push_back(runLen);
        runLen = 0;
      end
    end
  end
endmodule // pmd_mem_model
`default_nettype wire

//--- verif/pmd_decoder_tb.sv
// Self-checking bench for the prefixed move decoder.
`timescale 1ns/1ps
`default_nettype none
module pmd_decoder_tb
  import pmd_pkg::*;
;
  // ****************************************************************
  // Stimulus and wiring.
  // ****************************************************************
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic irqReq = 1'b0;
  logic dmaReq = 1'b0;
  logic dmaOn = 1'b0;
  logic slow = 1'b1;
  logic [1:0] dcnt = 2'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, fetchReq, fetchValid, memRd, memWr, irqAck, dmaGrant;
  logic [19:0] fetchAddr, memAddr;
  logic [7:0] fetchData, memWdata, memRdata;
  int fail_count = 0;
  int tests_run = 0;
  // ES is loaded before each prefixed access; the run ends in a branch to itself.
  logic [7:0] prog [25] = '{8'hc4, 8'h05, 8'h51, 8'h34, 8'h11, 8'hc8, 8'h00, 8'h12, 8'hc8,
    8'h00, 8'h12, 8'hc4, 8'h00, 8'h11, 8'hc7, 8'h40, 8'h00, 8'h61, 8'hc1, 8'hd1, 8'h8b,
    8'hcc, 8'h81, 8'hca, 8'hfe};

  pmd_decoder DUT (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchValid(fetchValid),
    .fetchData(fetchData), .memRd(memRd), .memWr(memWr), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .irqReq(irqReq), .irqAck(irqAck),
    .dmaReq(dmaReq), .dmaGrant(dmaGrant));
  pmd_mem_model MEM (.clk_sys(clk_sys), .nrst(nrst), .slow(slow), .fetchReq(fetchReq),
    .fetchAddr(fetchAddr), .fetchValid(fetchValid), .fetchData(fetchData), .memRd(memRd),
    .memWr(memWr), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .irqAck(irqAck), .dmaGrant(dmaGrant));

  // Clock, and DMA requests every third cycle so they drift against the fetch pace.
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    dcnt <= (dcnt == 2'h2) ? 2'h0 : dcnt + 2'h1;
    dmaReq <= dmaOn && (dcnt == 2'h0);
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic erv);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sc_reset();
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk("status", rd, {8'h00, ES_RST, PSW_RST, 8'h00});
    apb(1'b0, OFF_REGS_LO, 32'h0, rd, er);
    chk("regs", rd, REGS_RST[31:0]);
    apb(1'b0, 8'h40, 32'h0, rd, er);
    chk("unmapped", {31'h0, er}, 32'h1);
  endtask

  task automatic sc_program();
    int n;
    dmaOn <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h1, rd, er);
    n = 0;
    while (MEM.rLen.size() < 2 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (40) @(posedge clk_sys);
    apb(1'b1, OFF_CTRL, 32'h0, rd, er);
    dmaOn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("writes", MEM.wAddr.size(), 32'd2);
    chk("reads", MEM.rLen.size(), 32'd2);
    chk("ext write", {12'h0, MEM.wAddr[0]}, 32'h51200);
    chk("ext data", {24'h0, MEM.wData[0]}, 32'h34);
    chk("plain write", {12'h0, MEM.wAddr[1]}, 32'hf1200);
    chk("flash addr", {12'h0, MEM.rAddr[0]}, 32'h00040);
    chk("flash clocks", MEM.rLen[0], {29'h0, CYC_FLASH});
    chk("ram addr", {12'h0, MEM.rAddr[1]}, 32'hf0000);
    chk("ram clocks", MEM.rLen[1], {29'h0, CYC_RAM});
    apb(1'b0, OFF_REGS_LO, 32'h0, rd, er);
    chk("accumulator", rd, 32'h0000f000);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk("status", rd, 32'h0000d102);
    apb(1'b1, OFF_STATUS, 32'h2, rd, er);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk("status clear", rd, 32'h0000d100);
    apb(1'b0, OFF_PC, 32'h0, rd, er);
    chk("loop pc", rd, 32'h00000017);
  endtask

  // Interrupt taken at a boundary clears the enable, so only one is taken.
  task automatic sc_irq();
    int n;
    irqReq <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h1, rd, er);
    n = 0;
    while (MEM.irqCnt == 0 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (5) @(posedge clk_sys);
    irqReq <= 1'b0;
    apb(1'b1, OFF_CTRL, 32'h0, rd, er);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk("psw after irq", {24'h0, rd[15:8]}, 32'h51);
    chk("irq count", MEM.irqCnt, 32'd1);
    chk("prefix gap", MEM.viol, 32'd0);
  endtask

  // Code patched behind the stopped loop: restore, prefixed word, table slot, long branch.
  task automatic sc_word();
    int n;
    logic [7:0] more [8] = '{8'h00, 8'hcd, 8'h11, 8'hc9, 8'h81, 8'h00, 8'hcc, 8'h80};
    for (int i = 0; i < 8; i++) MEM.code[24 + i] = more[i];
    MEM.code[8'h80] = 8'hcb;
    MEM.code[8'h81] = 8'hfd;
    MEM.code[8'h82] = 8'hff;
    apb(1'b1, OFF_CTRL, 32'h1, rd, er);
    n = 0;
    while (MEM.rLen.size() < 4 && n < 500) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (30) @(posedge clk_sys);
    apb(1'b1, OFF_CTRL, 32'h0, rd, er);
    chk("word addr", {12'h0, MEM.rAddr[2]}, 32'h00080);
    chk("word clocks", MEM.rLen[2], 32'd8);
    chk("table addr", {12'h0, MEM.rAddr[3]}, 32'h00080);
    chk("table clocks", MEM.rLen[3], 32'd8);
    apb(1'b0, OFF_REGS_LO, 32'h0, rd, er);
    chk("word pair", rd, 32'h00008180);
    apb(1'b0, OFF_STATUS, 32'h0, rd, er);
    chk("restored psw", {24'h0, rd[15:8]}, 32'hd1);
    apb(1'b0, OFF_PC, 32'h0, rd, er);
    chk("table pc", rd, 32'h00008180);
  endtask

  // Main sequence.
  initial begin
    for (int i = 0; i < 256; i++) MEM.code[i] = (i < 25) ? prog[i] : 8'h00;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    sc_reset();
    sc_program();
    sc_irq();
    sc_word();
    end_sim();
  end

  // Watchdog, far beyond the few hundred cycles the run needs.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end
endmodule // pmd_decoder_tb
`default_nettype wire
